/* hdl/gcn_consts.svh */
// Register offsets, reset values and field sizes for the port block.
// Assumes inclusion by bare name from the package; design modules use its macros without including it.
`ifndef GCN_CONSTS_SVH
`define GCN_CONSTS_SVH

// ==========================================================
// Register word offsets
`define GCN_OFS_DIR       8'h00
`define GCN_OFS_PIN       8'h01
`define GCN_OFS_LAT       8'h02
`define GCN_OFS_ODC       8'h03
`define GCN_OFS_ANA       8'h04
`define GCN_OFS_CNEN_LO   8'h05
`define GCN_OFS_CNEN_HI   8'h06
`define GCN_OFS_CNPU_LO   8'h07
`define GCN_OFS_CNPU_HI   8'h08
`define GCN_OFS_CN_STAT   8'h09
`define GCN_OFS_LOCK      8'h0a
`define GCN_OFS_MAP_BASE  8'h10

// ==========================================================
// Reset values
`define GCN_DIR_RST       16'hffff
`define GCN_ANA_RST       16'h0000
`define GCN_SEL_RST       5'h1f
`define GCN_LOCK_RST      1'h0

// ==========================================================
// Field sizes
`define GCN_SEL_W         5
`define GCN_CN_LO_W       16

`endif

/* hdl/gcn_pkg.sv */
// Types shared by the port block modules.
// Assumes gcn_consts.svh is on the include path.
package gcn_pkg;
`include "gcn_consts.svh"

    // ======================================================
    // Register bus access kind
    typedef enum logic [2:0] {
        GCN_ACC_IDLE  = 3'b001,
        GCN_ACC_READ  = 3'b010,
        GCN_ACC_WRITE = 3'b100
    } gcn_acc_t;

endpackage

/* hdl/gcn_cn_detect.sv */
// Change-notification detector for one group of pins.
// Assumes inputs already synchronous to core_clk.
`timescale 1ns/1ps
module gcn_cn_detect #(
    parameter int W = 21
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Pins and control
    input  wire logic [W-1:0] pin_lvl,
    input  wire logic [W-1:0] enable,
    input  wire logic [W-1:0] clr_mask,
    input  wire logic         clr_stb,
    // Status
    output logic      [W-1:0] pending_q
);
    logic [W-1:0] last_q;
    logic [W-1:0] diff;

    assign diff = (pin_lvl ^ last_q) & enable;

    // ======================================================
    // Last sampled value
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_q <= '0;
        end else begin
            last_q <= pin_lvl;
        end
    end

    // ======================================================
    // Sticky flags; a new change wins over a clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pending_q <= '0;
        end else if (clr_stb) begin
            pending_q <= (pending_q & ~clr_mask) | diff;
        end else begin
            pending_q <= pending_q | diff;
        end
    end
endmodule // gcn_cn_detect

/* hdl/gcn_port.sv */
// One GPIO bank with pin sharing, change notify and input remapping.
// Assumes synchronous pins and a simple register port at core_clk.
`timescale 1ns/1ps
module gcn_port
    import gcn_pkg::*;
#(
    parameter int           NPIN    = 16,
    parameter logic [15:0]  IMPL    = 16'hffff,
    parameter logic [15:0]  ANA_CAP = 16'h00ff,
    parameter int           NCN     = 21,
    parameter int           NRP     = 26,
    parameter int           NMAP    = 22
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [15:0]          reg_rdata,
    // Pins
    input  wire logic [NPIN-1:0]      pin_in,
    output logic      [NPIN-1:0]      pin_out,
    output logic      [NPIN-1:0]      pin_oe,
    output logic      [NPIN-1:0]      pin_pullup,
    // Peripheral sharing
    input  wire logic [NPIN-1:0]      periph_en,
    input  wire logic [NPIN-1:0]      periph_drive,
    input  wire logic [NPIN-1:0]      periph_out,
    output logic      [NPIN-1:0]      periph_in,
    // Change notify sources and request
    input  wire logic [NCN-1:0]       cn_pin,
    output logic                      cn_irq,
    // Remappable pins and mapped peripheral inputs
    input  wire logic [NRP-1:0]       rp_pin,
    output logic      [NMAP-1:0]      map_in
);
    localparam int SW = `GCN_SEL_W;

    logic [15:0]       dir_q;
    logic [15:0]       lat_q;
    logic [15:0]       odc_q;
    logic [15:0]       ana_q;
    logic [NCN-1:0]    cnen_q;
    logic [NCN-1:0]    cnpu_q;
    logic              lock_q;
    logic [SW-1:0]     sel_q [NMAP];
    logic [NCN-1:0]    cn_pend;
    logic [NCN-1:0]    clr_mask;
    logic              clr_stb;
    logic [15:0]       pin_rd;
    logic [15:0]       rd_d;
    logic [NPIN-1:0]   own;
    logic [NPIN-1:0]   out_d;
    logic [NPIN-1:0]   oe_d;
    gcn_acc_t          acc;
    logic [15:0]       wmask;
    logic [2*16-1:0]   cn_ext;
    logic [2*16-1:0]   cn_wide;

    assign acc = reg_wr ? GCN_ACC_WRITE :
                 reg_rd ? GCN_ACC_READ : GCN_ACC_IDLE;
    assign wmask = IMPL;

    // ======================================================
    // Direction, latch, open drain, analog config
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir_q <= `GCN_DIR_RST & IMPL;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_DIR) begin
            dir_q <= reg_wdata & wmask;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lat_q <= '0;
        end else if (acc == GCN_ACC_WRITE &&
                     (reg_addr == `GCN_OFS_LAT ||
                      reg_addr == `GCN_OFS_PIN)) begin
            lat_q <= reg_wdata & wmask;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            odc_q <= '0;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_ODC) begin
            odc_q <= reg_wdata & wmask;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ana_q <= `GCN_ANA_RST;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_ANA) begin
            ana_q <= reg_wdata & ANA_CAP;
        end
    end

    // ======================================================
    // Change-notify enables and pull-ups, split low/high words
    assign cn_ext = {{(32-NCN){1'b0}}, cnen_q};
    assign cn_wide = {{(32-NCN){1'b0}}, cnpu_q};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnen_q <= '0;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_CNEN_LO) begin
            cnen_q[15:0] <= reg_wdata;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_CNEN_HI) begin
            cnen_q[NCN-1:16] <= reg_wdata[NCN-17:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnpu_q <= '0;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_CNPU_LO) begin
            cnpu_q[15:0] <= reg_wdata;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_CNPU_HI) begin
            cnpu_q[NCN-1:16] <= reg_wdata[NCN-17:0];
        end
    end

    // ======================================================
    // Map lock and input select fields
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lock_q <= `GCN_LOCK_RST;
        end else if (acc == GCN_ACC_WRITE &&
                     reg_addr == `GCN_OFS_LOCK) begin
            lock_q <= reg_wdata[0];
        end
    end

    // Input selects are kept apart from any output map
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NMAP; i++) begin
                sel_q[i] <= `GCN_SEL_RST;
            end
        end else if (acc == GCN_ACC_WRITE && !lock_q) begin
            for (int i = 0; i < NMAP; i++) begin
                if (reg_addr == `GCN_OFS_MAP_BASE + 8'(i)) begin
                    sel_q[i] <= reg_wdata[SW-1:0];
                end
            end
        end
    end

    // ======================================================
    // Change detection; write one to clear pending bits 15:0; bits 20:16 cannot be cleared
    assign clr_stb = (acc == GCN_ACC_WRITE) &&
                     (reg_addr == `GCN_OFS_CN_STAT);
    assign clr_mask = {{(NCN-16){1'b0}}, reg_wdata};

    // Pure sampling, no prescaler, so any change on an enabled pin is caught
    gcn_cn_detect #(
        .W         (NCN)
    ) u_cn (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_lvl   (cn_pin),
        .enable    (cnen_q),
        .clr_mask  (clr_mask),
        .clr_stb   (clr_stb),
        .pending_q (cn_pend)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cn_irq <= 1'b0;
        end else begin
            cn_irq <= |(cn_pend & cnen_q);
        end
    end

    // ======================================================
    // Pin ownership and drive
    always_comb begin
        own = periph_en & periph_drive;
        for (int i = 0; i < NPIN; i++) begin
            if (own[i]) begin
                out_d[i] = periph_out[i];
                oe_d[i] = 1'b1;
            end else if (odc_q[i]) begin
                out_d[i] = 1'b0;
                oe_d[i] = IMPL[i] & ~dir_q[i] & ~lat_q[i];
            end else begin
                out_d[i] = lat_q[i];
                oe_d[i] = IMPL[i] & ~dir_q[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
        end else begin
            pin_out <= out_d;
            pin_oe <= oe_d;
            pin_pullup <= cnpu_q[NPIN-1:0];
        end
    end

    // Peripheral sees only the pad, never the latch: no loop through
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            periph_in <= '0;
        end else begin
            periph_in <= pin_in & ~(IMPL & ~dir_q & ~own);
        end
    end

    // Mapping taps the pad level; direction still decides the driver
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            map_in <= '0;
        end else begin
            for (int i = 0; i < NMAP; i++) begin
                if (32'(sel_q[i]) < NRP) begin
                    map_in[i] <= rp_pin[sel_q[i]];
                end else begin
                    map_in[i] <= 1'b0;
                end
            end
        end
    end

    // ======================================================
    // Read path, data one cycle after the strobe
    // Config bit one is digital; analog-mode pins read low
    assign pin_rd = pin_in & IMPL & ana_q & ANA_CAP |
                    pin_in & IMPL & ~ANA_CAP;

    always_comb begin
        rd_d = '0;
        case (reg_addr)
            `GCN_OFS_DIR:     rd_d = dir_q & IMPL;
            `GCN_OFS_PIN:     rd_d = pin_rd;
            `GCN_OFS_LAT:     rd_d = lat_q & IMPL;
            `GCN_OFS_ODC:     rd_d = odc_q;
            `GCN_OFS_ANA:     rd_d = ana_q;
            `GCN_OFS_CNEN_LO: rd_d = cn_ext[15:0];
            `GCN_OFS_CNEN_HI: rd_d = cn_ext[31:16];
            `GCN_OFS_CNPU_LO: rd_d = cn_wide[15:0];
            `GCN_OFS_CNPU_HI: rd_d = cn_wide[31:16];
            `GCN_OFS_CN_STAT: rd_d = cn_pend[15:0];
            `GCN_OFS_LOCK:    rd_d = {15'h0000, lock_q};
            default: begin
                for (int i = 0; i < NMAP; i++) begin
                    if (reg_addr == `GCN_OFS_MAP_BASE + 8'(i)) begin
                        rd_d = {11'h000, sel_q[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (acc == GCN_ACC_READ) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule // gcn_port

/* tb/gcn_port_properties.sv */
// Checker for the port block: register port, pin sharing, notify, remap.
// Assumes it is bound to gcn_port and sees only that module's ports.
`timescale 1ns/1ps
module gcn_port_chk #(
    parameter int NPIN = 16,
    parameter int NRP  = 26,
    parameter int NMAP = 22
) (
    // Clock and reset
    input wire logic            core_clk,
    input wire logic            rst_n,
    // Register port
    input wire logic [7:0]      reg_addr,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [15:0]     reg_rdata,
    // Pins and peripherals
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NPIN-1:0] periph_en,
    input wire logic [NPIN-1:0] periph_drive,
    input wire logic [NPIN-1:0] periph_out,
    input wire logic [NPIN-1:0] periph_in,
    // Notify and remap
    input wire logic            cn_irq,
    input wire logic [NRP-1:0]  rp_pin,
    input wire logic [NMAP-1:0] map_in
);
    logic [NPIN-1:0] own;
    assign own = periph_en & periph_drive;

    // ==========
    // Properties
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property (
        $past(rst_n) && !$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h40 |-> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_owner_data: assert property (
        $past(rst_n) |-> ((pin_out ^ $past(periph_out)) & $past(own)) == '0)
        else $error("owned pin not fed by peripheral");
    a_owner_enable: assert property (
        $past(rst_n) |-> (~pin_oe & $past(own)) == '0)
        else $error("owned pin not enabled");
    a_no_loop: assert property (
        $past(rst_n) |-> (pin_oe & ~$past(own) & periph_in) == '0)
        else $error("port output loops into peripheral");
    a_reset_input: assert property (
        !$past(rst_n) |-> pin_oe == '0)
        else $error("pin driven after reset");
    a_irq_hold: assert property (
        $past(rst_n) && $past(rst_n, 2) && $fell(cn_irq)
        |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("notify request dropped without write");
    a_map_idle: assert property (
        $past(rst_n) && $past(rp_pin) == '0 |-> map_in == '0)
        else $error("mapped input high from idle pins");

    c_irq_rise: cover property ($rose(cn_irq));
    c_owned: cover property (|own && |pin_oe);
    c_read: cover property ($past(reg_rd) && reg_rdata != 16'h0);
endmodule // gcn_port_chk

bind gcn_port gcn_port_chk #(.NPIN(NPIN), .NRP(NRP), .NMAP(NMAP)) u_chk (
    .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .pin_out,
    .pin_oe, .periph_en, .periph_drive, .periph_out, .periph_in, .cn_irq,
    .rp_pin, .map_in);

/* tb/gcn_pad_model.sv */
// Pad and board model: port drive, board drive, pull-up or float.
// Assumes the bench never drives a pad that the port enables.
`timescale 1ns/1ps
module gcn_pad_model #(
    parameter int NPIN = 16
) (
    // Clock
    input  wire logic            core_clk,
    // Port side
    input  wire logic [NPIN-1:0] pin_out,
    input  wire logic [NPIN-1:0] pin_oe,
    input  wire logic [NPIN-1:0] pin_pullup,
    // Board side
    input  wire logic [NPIN-1:0] ext_val,
    input  wire logic [NPIN-1:0] ext_en,
    // Pad levels
    output logic      [NPIN-1:0] pin_in
);
    logic [NPIN-1:0] float_q = '0;
    // A floating pad wanders, so a stale level never passes for a read
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pullup[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_q[i];
        end
    end
endmodule // gcn_pad_model

/* tb/testbench.sv */
// Self-checking bench for the port block with a pad model.
// Assumes design files, pad model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] IMPL = 16'h7fff;
    logic        core_clk, rst_n, reg_wr, reg_rd, cn_irq;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pin_pullup;
    logic [15:0] periph_en, periph_drive, periph_out, periph_in;
    logic [15:0] ext_val, ext_en, rv;
    logic [20:0] cn_pin;
    logic [25:0] rp_pin;
    logic [21:0] map_in;
    logic [4:0]  sel_m [22];
    int          failures, compares, seed, i;

    gcn_port #(.IMPL(IMPL)) DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe,
        .pin_pullup, .periph_en, .periph_drive, .periph_out, .periph_in,
        .cn_pin, .cn_irq, .rp_pin, .map_in);
    gcn_pad_model u_pad (.core_clk, .pin_out, .pin_oe, .pin_pullup,
        .ext_val, .ext_en, .pin_in);

    // ==========
    // Tasks
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rc(logic [7:0] a, logic [15:0] e, string nm);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 chk(nm, reg_rdata, e);
        @(posedge core_clk);
    endtask
    task automatic mapchk;
        rp_pin <= 26'($random(seed));
        idle(2);
        for (int k = 0; k < 22; k++) begin
            chk("map", map_in[k], sel_m[k] < 26 ? rp_pin[sel_m[k]] : 1'b0);
        end
    endtask
    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        close_out();
    end

    // ==========
    // Scenarios
    initial begin
        seed = 84364;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {periph_en, periph_drive, periph_out, ext_val, ext_en} = '0;
        {cn_pin, rp_pin, failures, compares} = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk("oe rst", pin_oe, 16'h0);
        rc(8'h00, IMPL, "dir rst");
        rc(8'h04, 16'h0, "ana rst");
        rc(8'h40, 16'h0, "unmapped");
        wr(8'h04, 16'h00ff);
        wr(8'h00, 16'h0000);
        for (i = 0; i < 4; i++) begin
            rv = 16'($random(seed));
            wr((i % 2) ? 8'h01 : 8'h02, rv);
            idle(2);
            chk("oe", pin_oe, IMPL);
            chk("out", pin_out & IMPL, rv & IMPL);
            rc(8'h02, rv & IMPL, "lat");
            rc(8'h01, rv & IMPL, "pin");
        end
        wr(8'h03, 16'h000f);
        wr(8'h02, 16'h0005);
        idle(2);
        chk("od oe", pin_oe, 16'h7ffa);
        chk("od low", pin_out & pin_oe & 16'h000f, 16'h0);
        wr(8'h03, 16'h0000);
        wr(8'h00, 16'hffff);
        rv = 16'($random(seed));
        ext_en  <= 16'hffff;
        ext_val <= rv;
        wr(8'h04, 16'h000f);
        idle(2);
        rc(8'h01, rv & 16'h7f0f, "analog rd");
        wr(8'h04, 16'h00ff);
        wr(8'h00, 16'hff00);
        ext_en  <= 16'hff00;
        ext_val <= 16'h5500;
        wr(8'h02, 16'h00fe);
        periph_en    <= 16'h0003;
        periph_drive <= 16'h0001;
        periph_out   <= 16'h0001;
        // Peripheral input lags the pad by one more register stage
        idle(3);
        chk("own out", pin_out & 16'h00ff, 16'h00ff);
        chk("own oe", pin_oe, 16'h00ff);
        chk("loop", periph_in, 16'h5501);
        rc(8'h01, 16'h55ff, "shared rd");
        periph_drive <= 16'h0;
        idle(2);
        chk("freed", pin_out & 16'h0001, 16'h0);
        chk("freed oe", pin_oe & 16'h0001, 16'h1);
        periph_en <= 16'h0;
        for (i = 0; i < 22; i++) begin
            sel_m[i] = 5'($random(seed));
            wr(8'h10 + 8'(i), {11'h0, sel_m[i]});
        end
        repeat (3) mapchk();
        wr(8'h0a, 16'h0001);
        wr(8'h10, {11'h0, ~sel_m[0]});
        mapchk();
        rc(8'h10, {11'h0, sel_m[0]}, "map lock");
        rp_pin <= '0;
        idle(2);
        chk("map idle", map_in, 22'h0);
        wr(8'h0a, 16'h0000);
        wr(8'h05, 16'h0001);
        wr(8'h06, 16'h0010);
        cn_pin[1] <= 1'b1;
        idle(4);
        chk("cn off", cn_irq, 1'b0);
        cn_pin[0] <= 1'b1;
        idle(3);
        chk("cn on", cn_irq, 1'b1);
        rc(8'h09, 16'h0001, "cn stat");
        chk("cn hold", cn_irq, 1'b1);
        wr(8'h09, 16'h0001);
        idle(2);
        chk("cn clr", cn_irq, 1'b0);
        cn_pin[20] <= 1'b1;
        idle(3);
        chk("cn hi", cn_irq, 1'b1);
        wr(8'h00, 16'hffff);
        wr(8'h07, 16'ha5a5);
        idle(2);
        chk("pullup", pin_pullup, 16'ha5a5);
        close_out();
    end
endmodule // testbench
